/* File: rtl/omc_dbg_gate.sv */
// debug command gate: admits commands by mode, holds the entry enable
`timescale 1ns/1ns
`default_nettype none
module omc_dbg_gate
  import omc_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  omc_dbg_if.gate dbg // command side of the controller
);
  logic entry_en_ff;
  logic nxt_rsp_valid;
  logic [1:0] nxt_rsp_code;
  logic nxt_bkg, nxt_resume, nxt_trace, in_dbg, stopped;

  assign in_dbg = (dbg.mcls == MC_DBG);
  assign stopped = (dbg.mcls == MC_STOP);

  // admission by mode; unclocked debug logic in stop gives no answer
  always_comb begin
    nxt_rsp_valid = dbg.cmd_valid & (~stopped | entry_en_ff);
    nxt_rsp_code = RSP_REFUSED;
    nxt_bkg = 1'b0;
    nxt_resume = 1'b0;
    nxt_trace = 1'b0;
    unique case (dbg.cmd)
      CMD_MEM, CMD_READ_STATUS, CMD_WRITE_CONTROL: begin
        if (!stopped) nxt_rsp_code = RSP_OK;
      end
      CMD_MEM_STAT: begin
        nxt_rsp_code = stopped ? RSP_STOPPED : RSP_OK;
      end
      CMD_BACKGROUND: begin
        nxt_rsp_code = RSP_OK;
        nxt_bkg = nxt_rsp_valid;
      end
      CMD_CPU_REG, CMD_TRACE, CMD_RESUME: begin
        if (in_dbg) nxt_rsp_code = RSP_OK;
        nxt_trace = nxt_rsp_valid & in_dbg & (dbg.cmd == CMD_TRACE);
        nxt_resume = nxt_rsp_valid & in_dbg & (dbg.cmd == CMD_RESUME);
      end
    endcase
  end

  // answer and event flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg.rsp_valid <= 1'b0;
      dbg.rsp_code <= RSP_OK;
      dbg.rsp_rbit <= 1'b0;
      dbg.ev_bkg <= 1'b0;
      dbg.ev_resume <= 1'b0;
      dbg.ev_trace <= 1'b0;
    end else begin
      dbg.rsp_valid <= nxt_rsp_valid;
      dbg.rsp_code <= nxt_rsp_code;
      dbg.rsp_rbit <= entry_en_ff;
      dbg.ev_bkg <= nxt_bkg;
      dbg.ev_resume <= nxt_resume;
      dbg.ev_trace <= nxt_trace;
    end
  end

  // entry enable is reachable only through the write-control command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_en_ff <= 1'b0;
    end else if (nxt_rsp_valid && nxt_rsp_code == RSP_OK &&
                 dbg.cmd == CMD_WRITE_CONTROL) begin
      entry_en_ff <= dbg.cmd_wbit;
    end
  end
  assign dbg.entry_en = entry_en_ff;

  AST_STOP_MEM_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    dbg.cmd_valid && stopped && entry_en_ff && dbg.cmd == CMD_MEM_STAT
    |=> dbg.rsp_valid && dbg.rsp_code == RSP_STOPPED)
    else $error("status memory access in stop not answered stopped");
  AST_RESUME_ONLY_DBG: assert property (@(posedge pclk)
    disable iff (!presetn) dbg.cmd_valid && !in_dbg |=> !dbg.ev_resume)
    else $error("resume taken outside debug mode");
endmodule // omc_dbg_gate
`default_nettype wire

/* File: rtl/omc_dbg_if.sv */
// signals between the mode controller and its debug command gate
`timescale 1ns/1ns
`default_nettype none
interface omc_dbg_if;
  import omc_pkg::*;
  logic cmd_valid;
  logic [2:0] cmd;
  logic cmd_wbit;
  omc_mcls_t mcls;
  logic entry_en;
  logic rsp_valid;
  logic [1:0] rsp_code;
  logic rsp_rbit;
  logic ev_bkg;
  logic ev_resume;
  logic ev_trace;
  modport gate (input cmd_valid, cmd, cmd_wbit, mcls,
    output entry_en, rsp_valid, rsp_code, rsp_rbit, ev_bkg, ev_resume,
    ev_trace);
  modport ctl (output cmd_valid, cmd, cmd_wbit, mcls,
    input entry_en, rsp_valid, rsp_code, rsp_rbit, ev_bkg, ev_resume,
    ev_trace);
endinterface
`default_nettype wire

/* File: rtl/omc_pkg.sv */
// constants, types and register map of the operating mode controller
package omc_pkg;
  // clock and slow oscillator timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SLOW_OSC_PERIOD_NS = 1_000_000;
  localparam int SLOW_OSC_CYCLES = SLOW_OSC_PERIOD_NS / CLK_PERIOD_NS;
  // restart pseudo-vector pair
  localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hdffe;
  localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hdfff;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_LFDET_OFS = 8'h08;
  // control register fields (power_mode_control_one/two bits)
  localparam int CTRL_STOP_PERMIT_BIT = 0;
  localparam int CTRL_STOP_SEL_LSB = 1;
  localparam int CTRL_LOWVOLT_ON_BIT = 3;
  localparam int CTRL_LOWVOLT_STOP_BIT = 4;
  localparam int CTRL_TICK_SLOW_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // stop selection codes
  localparam logic [1:0] STOPSEL_DEEP = 2'h0;
  localparam logic [1:0] STOPSEL_INTERMEDIATE = 2'h1;
  localparam logic [1:0] STOPSEL_THIRD = 2'h2;
  localparam logic [1:0] STOPSEL_LIGHT = 2'h3;
  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ENTRY_EN_BIT = 3;
  localparam int STAT_LOWVOLT_BIT = 4;
  localparam int STAT_DBGCLK_BIT = 5;
  // lf detector sampling period minus one, in slow ticks
  localparam logic [7:0] LFDET_PERIOD_RESET = 8'h10;
  // debug command codes
  localparam logic [2:0] CMD_MEM = 3'h0;
  localparam logic [2:0] CMD_MEM_STAT = 3'h1;
  localparam logic [2:0] CMD_READ_STATUS = 3'h2;
  localparam logic [2:0] CMD_WRITE_CONTROL = 3'h3;
  localparam logic [2:0] CMD_BACKGROUND = 3'h4;
  localparam logic [2:0] CMD_CPU_REG = 3'h5;
  localparam logic [2:0] CMD_TRACE = 3'h6;
  localparam logic [2:0] CMD_RESUME = 3'h7;
  // debug answer codes
  localparam logic [1:0] RSP_OK = 2'h0;
  localparam logic [1:0] RSP_REFUSED = 2'h1;
  localparam logic [1:0] RSP_STOPPED = 2'h2;
  // operating states
  typedef enum logic [2:0] {
    ST_BOOT, ST_RUN, ST_DBG, ST_DEEP, ST_LIGHT, ST_THIRD
  } omc_state_t;
  // mode class seen by the debug command gate
  typedef enum logic [1:0] {MC_RUN, MC_DBG, MC_STOP} omc_mcls_t;
endpackage

/* File: rtl/omc_top.sv */
// operating mode controller: run, debug and stop mode sequencing
//
// Overview of operation
// - debug pin high at reset: run from vector
// - four ways into debug mode
// - debug mode suspends cpu awaiting commands
// - non-intrusive commands accepted in run and debug
// - cpu, trace, resume commands only in debug
// - permitted stop halts clocks except slow oscillator
// - stop without permit forces illegal-opcode reset
// - stop variant chosen by control bits
// - deep stop powers down, regulator standby
// - deep stop asserts low voltage, waits rearm
// - deep stop wake restarts like power-on
// - pending interrupt blocks deep stop entry
// - low voltage in stop turns deep into light
// - slow oscillator, wakeup unit always running
// - light stop keeps power and regulation
// - tick runs in stop only on slow clock
// - medium oscillator started by listed stop activity
// - debug entry from run needs entry enable
// - entry enable keeps debug clocks, light stop; a third stop selection still enters third stop
// - stop: most commands refused, status reports stopped
// - background command wakes stop into debug
// - rf buffer runs; lf detector sampled periodically
// - deep stop puts pins high impedance
// - deep stop wake resets modules, drops ram
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module omc_top
  import omc_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_OSC_CYCLES // cycles per slow tick
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic debug_pin, // debug pin level
  input wire logic stop_instr, // cpu executes stop
  input wire logic break_instr, // cpu executes break instruction
  input wire logic bkpt_hit, // debug breakpoint match
  input wire logic irq_pending, // an interrupt awaits service
  input wire logic wake_irq, // wakeup interrupt request
  input wire logic supply_rearm, // supply above low-voltage rearm
  input wire logic lfdet_hit, // lf detector senses a signal
  input wire logic sensor_busy, // pressure or accel reading active
  input wire logic rf_sending, // rf state machine sending
  input wire logic rf_buf_req, // rf buffer asked to run
  input wire logic dbg_cmd_valid, // debug command strobe
  input wire logic [2:0] dbg_cmd, // debug command code
  input wire logic dbg_cmd_wbit, // entry enable value to write
  output logic dbg_rsp_valid, // debug answer strobe
  output logic [1:0] dbg_rsp_code, // debug answer code
  output logic dbg_rsp_rbit, // entry enable read back
  output logic cpu_run, // cpu fetches user code
  output logic cpu_step, // single instruction trace pulse
  output logic vec_fetch, // fetch reset vector pulse
  output logic [15:0] vec_addr, // pseudo-vector high address
  output logic illegal_rst, // illegal-opcode reset pulse
  output logic periph_rst, // module registers reset pulse
  output logic sys_clk_on, // system clocks running
  output logic dbg_clk_on, // debug logic clock running
  output logic reg_standby, // regulator in low-power standby
  output logic core_power_on, // regulated circuits powered
  output logic lowvolt_flag, // low voltage detect asserted
  output logic io_hiz, // pins forced high impedance
  output logic slow_osc_on, // slow oscillator enabled
  output logic wakeup_unit_on, // periodic wakeup unit enabled
  output logic med_osc_on, // medium oscillator enabled
  output logic tick_run, // periodic tick interrupt clocked
  output logic lfdet_power, // lf detector sample pulse
  output logic rf_buf_run // rf data buffer running
);
  if (SLOW_DIV < 2) begin : g_chk
    $error("SLOW_DIV must be at least 2");
  end

  omc_dbg_if dbg ();
  omc_dbg_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .dbg(dbg)
  );

  omc_state_t state_ff, nxt_state;
  logic [5:0] ctrl_ff;
  logic [7:0] lfdet_period_ff;
  logic stop_permit, lowvolt_detect_on, lowvolt_detect_in_stop;
  logic [1:0] stop_sel;
  logic tick_slow, entry_en, in_stop, deep_req, go_light, dbg_entry;
  logic apb_setup, apb_wr, mapped;

  assign stop_permit = ctrl_ff[CTRL_STOP_PERMIT_BIT];
  assign stop_sel = ctrl_ff[CTRL_STOP_SEL_LSB +: 2];
  assign lowvolt_detect_on = ctrl_ff[CTRL_LOWVOLT_ON_BIT];
  assign lowvolt_detect_in_stop = ctrl_ff[CTRL_LOWVOLT_STOP_BIT];
  assign tick_slow = ctrl_ff[CTRL_TICK_SLOW_BIT];
  assign entry_en = dbg.entry_en;
  assign in_stop = (state_ff == ST_DEEP) || (state_ff == ST_LIGHT) ||
                   (state_ff == ST_THIRD);

  // debug command port into the gate
  assign dbg.cmd_valid = dbg_cmd_valid;
  assign dbg.cmd = dbg_cmd;
  assign dbg.cmd_wbit = dbg_cmd_wbit;
  assign dbg.mcls = in_stop ? MC_STOP :
                    (state_ff == ST_DBG) ? MC_DBG : MC_RUN;

  // intermediate variant is absent; its code falls back to light stop
  assign deep_req = (stop_sel == STOPSEL_DEEP);
  // either override keeps regulation, so deep becomes light
  assign go_light = (lowvolt_detect_on & lowvolt_detect_in_stop) |
                    entry_en;
  // debug entry from run is gated by entry enable
  assign dbg_entry = entry_en &
                     (break_instr | bkpt_hit | dbg.ev_bkg);

  // mode sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_BOOT: begin
        nxt_state = debug_pin ? ST_RUN : ST_DBG;
      end
      ST_RUN: begin
        if (dbg_entry) begin
          nxt_state = ST_DBG;
        end else if (stop_instr && !stop_permit) begin
          nxt_state = ST_BOOT;
        end else if (stop_instr) begin
          if (stop_sel == STOPSEL_THIRD) nxt_state = ST_THIRD;
          else if (!deep_req || go_light) nxt_state = ST_LIGHT;
          else if (!irq_pending) nxt_state = ST_DEEP;
        end
      end
      ST_DBG: begin
        if (dbg.ev_resume) nxt_state = ST_RUN;
      end
      ST_DEEP: begin
        // wake needs an interrupt and the supply back above rearm
        if (wake_irq && supply_rearm) nxt_state = ST_BOOT;
      end
      ST_LIGHT, ST_THIRD: begin
        if (dbg.ev_bkg && entry_en) nxt_state = ST_DBG;
        else if (wake_irq) nxt_state = ST_RUN;
      end
    endcase
  end

  // state register; a deep stop wake passes through boot like power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // restart and reset pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_fetch <= 1'b0;
      vec_addr <= RESET_VEC_HI_ADDR;
      illegal_rst <= 1'b0;
      periph_rst <= 1'b0;
      cpu_step <= 1'b0;
    end else begin
      vec_fetch <= (state_ff == ST_BOOT) && debug_pin;
      vec_addr <= RESET_VEC_HI_ADDR;
      illegal_rst <= (state_ff == ST_RUN) && !dbg_entry &&
                     stop_instr && !stop_permit;
      periph_rst <= (state_ff == ST_DEEP) &&
                    (nxt_state == ST_BOOT);
      cpu_step <= dbg.ev_trace;
    end
  end

  // clock and power controls follow the next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_run <= 1'b0;
      sys_clk_on <= 1'b1;
      dbg_clk_on <= 1'b1;
      reg_standby <= 1'b0;
      core_power_on <= 1'b1;
      lowvolt_flag <= 1'b0;
      io_hiz <= 1'b1;
    end else begin
      cpu_run <= (nxt_state == ST_RUN);
      // only the debug override keeps system clocks in light stop
      sys_clk_on <= !(nxt_state inside {ST_DEEP, ST_LIGHT, ST_THIRD}) ||
                    (nxt_state == ST_LIGHT && entry_en);
      dbg_clk_on <= !(nxt_state inside {ST_DEEP, ST_LIGHT, ST_THIRD}) ||
                    entry_en && nxt_state != ST_DEEP;
      reg_standby <= (nxt_state == ST_DEEP) ||
                     (nxt_state == ST_THIRD && !go_light);
      core_power_on <= (nxt_state != ST_DEEP);
      lowvolt_flag <= (nxt_state == ST_DEEP);
      io_hiz <= (nxt_state == ST_DEEP) || (nxt_state == ST_BOOT);
    end
  end

  // slow oscillator tick divider, kept on in every mode
  localparam int DIVW = $clog2(SLOW_DIV);
  logic [DIVW-1:0] div_ff;
  logic slow_tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
    end else if (div_ff == DIVW'(SLOW_DIV - 1)) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end
  assign slow_tick = (div_ff == DIVW'(SLOW_DIV - 1));

  // lf detector sampling once every programmed number plus one of slow ticks
  logic [7:0] lf_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_cnt_ff <= 8'h00;
      lfdet_power <= 1'b0;
    end else begin
      lfdet_power <= 1'b0;
      if (slow_tick) begin
        if (lf_cnt_ff >= lfdet_period_ff) begin
          lf_cnt_ff <= 8'h00;
          lfdet_power <= 1'b1;
        end else begin
          lf_cnt_ff <= lf_cnt_ff + 8'h01;
        end
      end
    end
  end

  // always-on and activity driven blocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_osc_on <= 1'b1;
      wakeup_unit_on <= 1'b1;
      med_osc_on <= 1'b0;
      tick_run <= 1'b0;
      rf_buf_run <= 1'b0;
    end else begin
      slow_osc_on <= 1'b1;
      wakeup_unit_on <= 1'b1;
      // the medium oscillator costs power, so in stop it only runs
      // while one of its users needs it
      med_osc_on <= !(nxt_state inside {ST_DEEP, ST_LIGHT, ST_THIRD}) ||
                    lfdet_power || lfdet_hit || sensor_busy ||
                    rf_sending;
      tick_run <= tick_slow || (nxt_state == ST_RUN);
      rf_buf_run <= rf_buf_req;
    end
  end

  // apb slave, zero wait states; read data caught in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign mapped = (paddr == REG_CTRL_OFS) || (paddr == REG_STATUS_OFS) ||
                  (paddr == REG_LFDET_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      lfdet_period_ff <= LFDET_PERIOD_RESET;
    end else if (apb_wr && paddr == REG_CTRL_OFS) begin
      ctrl_ff <= pwdata[5:0];
    end else if (apb_wr && paddr == REG_LFDET_OFS) begin
      lfdet_period_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        pslverr <= !mapped;
        prdata <= 32'h0000_0000;
        if (paddr == REG_CTRL_OFS) begin
          prdata[5:0] <= ctrl_ff;
        end else if (paddr == REG_STATUS_OFS) begin
          prdata[STAT_STATE_LSB +: 3] <= state_ff;
          prdata[STAT_ENTRY_EN_BIT] <= entry_en;
          prdata[STAT_LOWVOLT_BIT] <= lowvolt_flag;
          prdata[STAT_DBGCLK_BIT] <= dbg_clk_on;
        end else if (paddr == REG_LFDET_OFS) begin
          prdata[7:0] <= lfdet_period_ff;
        end
      end
    end
  end

  // debug answer to the top ports, already registered in the gate
  assign dbg_rsp_valid = dbg.rsp_valid;
  assign dbg_rsp_code = dbg.rsp_code;
  assign dbg_rsp_rbit = dbg.rsp_rbit;

  // checks
  sequence s_stop_deep_req;
    state_ff == ST_RUN && !dbg_entry && stop_instr && stop_permit &&
      stop_sel == STOPSEL_DEEP;
  endsequence

  AST_BOOT_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_BOOT && debug_pin |=> state_ff == ST_RUN && vec_fetch
    && vec_addr == RESET_VEC_HI_ADDR)
    else $error("pin high at boot did not start run at vector");
  AST_BOOT_DBG: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_BOOT && !debug_pin |=> state_ff == ST_DBG && !cpu_run)
    else $error("pin low at boot did not enter debug mode");
  AST_ILLEGAL: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_RUN && !dbg_entry && stop_instr && !stop_permit
    |=> illegal_rst && state_ff == ST_BOOT ##1 !illegal_rst)
    else $error("unpermitted stop did not force one reset pulse");
  AST_DEEP_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    s_stop_deep_req and (!go_light && !irq_pending) |=> state_ff == ST_DEEP
    && lowvolt_flag && reg_standby && io_hiz && !sys_clk_on)
    else $error("deep stop entry outputs wrong");
  AST_DEEP_BLOCKED: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_stop_deep_req and (!go_light && irq_pending) |=> state_ff == ST_RUN)
    else $error("deep stop entered with interrupt pending");
  AST_OVERRIDE_LIGHT: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_stop_deep_req and entry_en |=> state_ff == ST_LIGHT && dbg_clk_on
    && sys_clk_on && !reg_standby)
    else $error("debug override did not give light stop with clocks");
  AST_DEEP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_DEEP && !supply_rearm |=> state_ff == ST_DEEP)
    else $error("deep stop left before supply rearm");
  AST_DEEP_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_DEEP && wake_irq && supply_rearm
    |=> periph_rst && state_ff == ST_BOOT ##1 state_ff != ST_BOOT)
    else $error("deep stop wake did not restart as power-on");
  AST_ALWAYS_ON: assert property (@(posedge pclk) disable iff (!presetn)
    in_stop |-> slow_osc_on && wakeup_unit_on)
    else $error("always-on block off in stop");
endmodule // omc_top
`default_nettype wire

/* File: tb/omc_dbg_host.sv */
// model of the background debug host on the command port
`timescale 1ns/1ns
`default_nettype none
module omc_dbg_host (
  input wire logic pclk, // system clock
  output logic cmd_valid, // command strobe
  output logic [2:0] cmd, // command code
  output logic wbit, // entry enable value to write
  input wire logic rsp_valid, // answer strobe
  input wire logic [1:0] rsp_code, // answer code
  input wire logic rsp_rbit // entry enable read back
);
  // idle port at time zero
  initial begin
    cmd_valid = 1'h0;
    cmd = 3'h0;
    wbit = 1'h0;
  end
  // one command, then catch the one-cycle answer
  // entry enable only changes through write-control here
  // background is the only wake request it sends in stop
  task automatic send(input logic [2:0] c, input logic w, output logic got,
    output logic [1:0] code, output logic rb);
    @(posedge pclk);
    cmd_valid <= 1'h1;
    cmd <= c;
    wbit <= w;
    @(posedge pclk);
    cmd_valid <= 1'h0;
    cmd <= ~c; // released lines must not keep the old code
    wbit <= ~w;
    got = 1'h0;
    repeat (3) begin
      #1;
      if (rsp_valid === 1'h1 && !got) begin
        got = 1'h1;
        code = rsp_code;
        rb = rsp_rbit;
      end
      @(posedge pclk);
    end
  endtask
endmodule // omc_dbg_host
`default_nettype wire

/* File: tb/omc_top_tb_top.sv */
// self-checking bench of the operating mode controller
`timescale 1ns/1ns
`default_nettype none
module omc_top_tb_top;
  import omc_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, debug_pin = 1'h1, stop_instr = 1'h0;
  logic break_instr = 1'h0, bkpt_hit = 1'h0, irq_pending = 1'h0;
  logic wake_irq = 1'h0, supply_rearm = 1'h0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic dv, dw, rv, rb, got, cpu_run, vec_fetch, ill, per, dclk, stby;
  logic [2:0] dc;
  logic [1:0] rc;
  logic [15:0] vec_addr;
  logic core_on, lowv, hiz, slow_on, sclk, tk, wk, mo, rbr, stp;
  // answer fields caught by the host, apart from the design's own outputs
  logic [1:0] ac;
  logic ab, rfq = 1'h0, sns = 1'h0;
  int failures = 0, n_compared = 0, n_vec = 0, n_ill = 0, n_per = 0;
  int n_stp = 0;
  // 4 ns clock; the slow tick is shortened to 8 cycles
  always #2 pclk = ~pclk;
  omc_top #(.SLOW_DIV(8)) u_omc_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_pin(debug_pin), .stop_instr(stop_instr),
    .break_instr(break_instr), .bkpt_hit(bkpt_hit),
    .irq_pending(irq_pending), .wake_irq(wake_irq),
    .supply_rearm(supply_rearm), .lfdet_hit(1'h0), .sensor_busy(sns),
    .rf_sending(1'h0), .rf_buf_req(rfq), .dbg_cmd_valid(dv),
    .dbg_cmd(dc), .dbg_cmd_wbit(dw), .dbg_rsp_valid(rv),
    .dbg_rsp_code(rc), .dbg_rsp_rbit(rb), .cpu_run(cpu_run),
    .cpu_step(stp), .vec_fetch(vec_fetch), .vec_addr(vec_addr),
    .illegal_rst(ill), .periph_rst(per), .sys_clk_on(sclk), .dbg_clk_on(dclk),
    .reg_standby(stby), .core_power_on(core_on), .lowvolt_flag(lowv),
    .io_hiz(hiz), .slow_osc_on(slow_on), .wakeup_unit_on(wk),
    .med_osc_on(mo), .tick_run(tk), .lfdet_power(), .rf_buf_run(rbr));
  omc_dbg_host u_omc_dbg_host (.pclk(pclk), .cmd_valid(dv), .cmd(dc),
    .wbit(dw), .rsp_valid(rv), .rsp_code(rc), .rsp_rbit(rb));
  // pulses are counted, so a missed or doubled one shows
  always @(posedge pclk) begin
    if (vec_fetch === 1'h1) n_vec++;
    if (ill === 1'h1) n_ill++;
    if (per === 1'h1) n_per++;
    if (stp === 1'h1) n_stp++;
  end
  task automatic chk(input string n, input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no wait count assumed; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic st(input logic [2:0] e);
    apb(1'h0, REG_STATUS_OFS, 32'h0000_0000);
    chk("state", rd[2:0], e);
  endtask
  task automatic cmd(input logic [2:0] c, input logic w, input logic [1:0] e);
    u_omc_dbg_host.send(c, w, got, ac, ab);
    chk("answer", {got, ac}, {1'h1, e});
  endtask
  // one-cycle pulse: 0 stop, 1 break, 2 breakpoint
  task automatic pulse(input int k);
    @(posedge pclk);
    stop_instr <= (k == 0);
    break_instr <= (k == 1);
    bkpt_hit <= (k == 2);
    @(posedge pclk);
    stop_instr <= 1'h0;
    break_instr <= 1'h0;
    bkpt_hit <= 1'h0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic rst(input logic pin);
    @(posedge pclk);
    presetn <= 1'h0;
    debug_pin <= pin;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic t_boot();
    int v = n_vec;
    rst(1'h1);
    chk("vec", n_vec - v, 1);
    chk("run", cpu_run, 1'h1);
    chk("vaddr", vec_addr, RESET_VEC_HI_ADDR);
    apb(1'h0, REG_LFDET_OFS, 32'h0000_0000);
    chk("lfdet", rd[7:0], LFDET_PERIOD_RESET);
    apb(1'h0, 8'h0c, 32'h0000_0000);
    chk("slverr", err, 1'h1);
    $display("test boot done");
  endtask
  task automatic t_dbg();
    rst(1'h0);
    st(3'h2);
    cmd(CMD_RESUME, 1'h0, RSP_OK);
    st(3'h1);
    cmd(CMD_TRACE, 1'h0, RSP_REFUSED);
    cmd(CMD_MEM_STAT, 1'h0, RSP_OK);
    u_omc_dbg_host.send(CMD_BACKGROUND, 1'h0, got, ac, ab);
    st(3'h1);
    cmd(CMD_WRITE_CONTROL, 1'h1, RSP_OK);
    cmd(CMD_READ_STATUS, 1'h0, RSP_OK);
    chk("rbit", ab, 1'h1);
    for (int k = 1; k < 4; k++) begin
      if (k < 3) pulse(k);
      else cmd(CMD_BACKGROUND, 1'h0, RSP_OK);
      chk("held", cpu_run, 1'h0);
      st(3'h2);
      cmd(CMD_CPU_REG, 1'h0, RSP_OK);
      cmd(CMD_TRACE, 1'h0, RSP_OK);
      cmd(CMD_RESUME, 1'h0, RSP_OK);
    end
    chk("steps", n_stp, 3);
    $display("test debug done");
  endtask
  task automatic t_stop();
    int v = n_ill;
    apb(1'h1, REG_CTRL_OFS, 32'h0000_0001);
    pulse(0);
    st(3'h4);
    chk("dbgclk", {dclk, stby, core_on, slow_on}, 4'hb);
    chk("sysclk", sclk, 1'h1);
    cmd(CMD_MEM_STAT, 1'h0, RSP_STOPPED);
    cmd(CMD_TRACE, 1'h0, RSP_REFUSED);
    cmd(CMD_BACKGROUND, 1'h0, RSP_OK);
    st(3'h2);
    cmd(CMD_RESUME, 1'h0, RSP_OK);
    apb(1'h1, REG_CTRL_OFS, 32'h0000_0000);
    pulse(0);
    chk("illegal", n_ill - v, 1);
    $display("test stop done");
  endtask
  task automatic t_deep();
    int v = n_vec;
    int p = n_per;
    rst(1'h1);
    apb(1'h1, REG_CTRL_OFS, 32'h0000_0019);
    pulse(0);
    st(3'h4);
    rst(1'h1);
    apb(1'h1, REG_CTRL_OFS, 32'h0000_0001);
    irq_pending <= 1'h1;
    pulse(0);
    chk("irqblk", {cpu_run, stby}, 2'h2);
    @(posedge pclk);
    irq_pending <= 1'h0;
    pulse(0);
    chk("deep", {stby, core_on, hiz, lowv, slow_on}, 5'h17);
    chk("deepclk", {sclk, tk, wk}, 3'h1);
    @(posedge pclk);
    wake_irq <= 1'h1;
    rfq <= 1'h1;
    sns <= 1'h1;
    repeat (6) @(posedge pclk);
    #1;
    chk("rearm", {cpu_run, rbr, mo}, 3'h3);
    @(posedge pclk);
    supply_rearm <= 1'h1;
    sns <= 1'h0;
    repeat (8) @(posedge pclk);
    chk("wake", n_per - p, 1);
    chk("vecs", n_vec - v, 3);
    wake_irq <= 1'h0;
    supply_rearm <= 1'h0;
    $display("test deep stop done");
  endtask
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    t_boot();
    t_dbg();
    t_stop();
    t_deep();
    print_verdict();
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule // omc_top_tb_top
`default_nettype wire
